// ### rtl/adc_front_pkg.sv
// Constants and types for the converter front-end control block
// Functional notes
// - Sources 0000, 0100, 11xx route external channel
// - Other source codes pick internal signals
// - Internal source disconnects every external channel
// - Channel codes 0101-1111 leave input floating
// - Input-select bit 3 reads zero
// - Converter clock is system clock over 2^n
// - Amplifier enable bit; software sets when used
// - Reference control bits 6,5 read zero
// - Bandgap amplifier input switches reference pin off
// - Reference source: supply, pin, amplifier
// - Internal reference disconnects external reference pin
// - Gain field sets amplifier gain code
// - Bandgap enable bit 0; bits 7-1 zero
// - Analog pin loses function and pull-high
// - Analog pin overrides port direction
// - Channel codes 0,1,3,4 valid; 2 reserved
package adc_front_pkg;
  localparam int          ADDR_W        = 4;
  localparam logic [3:0]  ISEL_OFFSET   = 4'h0;
  localparam logic [3:0]  RAMP_OFFSET   = 4'h1;
  localparam logic [3:0]  BGAP_OFFSET   = 4'h2;
  localparam logic [3:0]  CHSEL_OFFSET  = 4'h3;
  localparam logic [3:0]  STAT_OFFSET   = 4'h4;
  localparam logic [7:0]  ISEL_MASK     = 8'hF7;
  localparam logic [7:0]  RAMP_MASK     = 8'h9F;
  localparam logic [7:0]  BGAP_MASK     = 8'h01;
  localparam logic [7:0]  CHSEL_MASK    = 8'h0F;
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam int          SRC_MSB       = 7;
  localparam int          SRC_LSB       = 4;
  localparam int          DIV_MSB       = 2;
  localparam int          AMP_EN_BIT    = 7;
  localparam int          AMP_IN_BIT    = 4;
  localparam int          REF_MSB       = 3;
  localparam int          REF_LSB       = 2;
  localparam int          GAIN_MSB      = 1;
  localparam int          BG_EN_BIT     = 0;
  localparam int          NUM_CHANNELS  = 5;
  localparam int          PIN_COUNT     = 5;

  typedef enum logic [3:0] {
    SRC_NONE    = 4'h0,
    SRC_EXT     = 4'h1,
    SRC_VDD     = 4'h2,
    SRC_VDD_2   = 4'h3,
    SRC_VDD_4   = 4'h4,
    SRC_AMP     = 4'h5,
    SRC_AMP_2   = 4'h6,
    SRC_AMP_4   = 4'h7,
    SRC_VSS     = 4'h8
  } conv_source_t;

  typedef enum logic [1:0] {
    REF_SUPPLY  = 2'h0,
    REF_PIN     = 2'h1,
    REF_AMP     = 2'h2
  } ref_source_t;
endpackage

// ### rtl/conv_clock_divider.sv
// Power-of-two divider that makes the converter clock enable
`timescale 1ns/1ps
module conv_clock_divider #(
  parameter int DIV_W = 3
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [DIV_W-1:0] conv_clock_divider,
  output logic                  conv_clk_tick
);
  localparam int CNT_W = (1 << DIV_W) - 1;

  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] limit;

  // Divide by 2^n: tick every 2^n system clocks
  assign limit = CNT_W'((1 << conv_clock_divider) - 1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= '0;
    end else if (count_ff >= limit) begin
      count_ff <= '0;
    end else begin
      count_ff <= count_ff + CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_clk_tick <= 1'b0;
    end else begin
      conv_clk_tick <= (count_ff >= limit);
    end
  end

  tick_period_a: assert property (@(posedge clk) disable iff (!rst_n)
    $stable(conv_clock_divider) && conv_clock_divider == '0 && $past(rst_n)
    |=> conv_clk_tick)
    else $error("Undivided clock lost a tick");
endmodule

// ### rtl/adc_input_reference_select_ctrl.sv
// Register file and analog switch control of the converter front end
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module adc_input_reference_select_ctrl
  import adc_front_pkg::*;
#(
  parameter int NCH = adc_front_pkg::NUM_CHANNELS
) (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  input  wire logic [adc_front_pkg::ADDR_W-1:0]  addr,
  input  wire logic [7:0]                        wdata,
  input  wire logic                              wr_en,
  input  wire logic                              rd_en,
  input  wire logic [NCH-1:0]                    analog_pin_select,
  output logic [7:0]                             rdata,
  output logic [NCH-1:0]                         external_analog_channel,
  output adc_front_pkg::conv_source_t            conv_source,
  output logic                                   ref_amp_enable,
  output logic                                   ref_amp_input_select,
  output logic                                   amp_reference_in_pin,
  output adc_front_pkg::ref_source_t             reference_source,
  output logic                                   ext_reference_pin,
  output logic [1:0]                             ref_amp_gain_select,
  output logic                                   bandgap_enable,
  output logic                                   conv_clk_tick,
  output logic [NCH-1:0]                         pin_digital_off,
  output logic [NCH-1:0]                         pin_pullhigh_off,
  output logic [NCH-1:0]                         pin_dir_override
);
  import adc_front_pkg::*;

  logic [7:0]     isel_ff;
  logic [7:0]     ramp_ff;
  logic [7:0]     bgap_ff;
  logic [7:0]     chsel_ff;
  conv_source_t   nxt_source;
  ref_source_t    nxt_ref;
  logic [NCH-1:0] nxt_channels;
  logic [7:0]     nxt_rdata;
  logic           ext_src;

  // Implemented bits only; writes to the rest are dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      isel_ff <= REG_RESET;
    end else if (wr_en && addr == ISEL_OFFSET) begin
      isel_ff <= wdata & ISEL_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_ff <= REG_RESET;
    end else if (wr_en && addr == RAMP_OFFSET) begin
      ramp_ff <= wdata & RAMP_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bgap_ff <= REG_RESET;
    end else if (wr_en && addr == BGAP_OFFSET) begin
      bgap_ff <= wdata & BGAP_MASK;
    end
  end

  // Channel field kept locally so the block is self-contained
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chsel_ff <= REG_RESET;
    end else if (wr_en && addr == CHSEL_OFFSET) begin
      chsel_ff <= wdata & CHSEL_MASK;
    end
  end

  function automatic conv_source_t decode_source(input logic [3:0] code);
    conv_source_t s;
    s = SRC_EXT;
    case (code)
      4'h0, 4'h4, 4'hC, 4'hD, 4'hE, 4'hF: s = SRC_EXT;
      4'h1: s = SRC_VDD;
      4'h2: s = SRC_VDD_2;
      4'h3: s = SRC_VDD_4;
      4'h5: s = SRC_AMP;
      4'h6: s = SRC_AMP_2;
      4'h7: s = SRC_AMP_4;
      4'h8, 4'h9, 4'hA, 4'hB: s = SRC_VSS;
      default: s = SRC_EXT;
    endcase
    return s;
  endfunction

  // One-hot channel switch; reserved and missing codes close nothing
  function automatic logic [NCH-1:0] decode_channel(input logic [3:0] code);
    logic [NCH-1:0] c;
    c = '0;
    case (code)
      4'h0: c[0] = 1'b1;
      4'h1: c[1] = 1'b1;
      4'h3: c[3] = 1'b1;
      4'h4: c[4] = 1'b1;
      default: c = '0;
    endcase
    return c;
  endfunction

  always_comb begin
    nxt_source = decode_source(isel_ff[SRC_MSB:SRC_LSB]);
    ext_src = (nxt_source == SRC_EXT);
    nxt_channels = ext_src ? decode_channel(chsel_ff[3:0]) : '0;
    case (ramp_ff[REF_MSB:REF_LSB])
      2'h0: nxt_ref = REF_SUPPLY;
      2'h1: nxt_ref = REF_PIN;
      default: nxt_ref = REF_AMP;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_source <= SRC_NONE;
      external_analog_channel <= '0;
    end else begin
      conv_source <= nxt_source;
      external_analog_channel <= nxt_channels;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_amp_enable <= 1'b0;
      ref_amp_input_select <= 1'b0;
      amp_reference_in_pin <= 1'b0;
      reference_source <= REF_SUPPLY;
      ext_reference_pin <= 1'b0;
      ref_amp_gain_select <= 2'h0;
      bandgap_enable <= 1'b0;
    end else begin
      ref_amp_enable <= ramp_ff[AMP_EN_BIT];
      ref_amp_input_select <= ramp_ff[AMP_IN_BIT];
      amp_reference_in_pin <= ~ramp_ff[AMP_IN_BIT];
      reference_source <= nxt_ref;
      ext_reference_pin <= (nxt_ref == REF_PIN);
      ref_amp_gain_select <= ramp_ff[GAIN_MSB:0];
      bandgap_enable <= bgap_ff[BG_EN_BIT];
    end
  end

  // Analog pins drop digital function, pull-high and direction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_digital_off <= '0;
      pin_pullhigh_off <= '0;
      pin_dir_override <= '0;
    end else begin
      pin_digital_off <= analog_pin_select;
      pin_pullhigh_off <= analog_pin_select;
      pin_dir_override <= analog_pin_select;
    end
  end

  always_comb begin
    case (addr)
      ISEL_OFFSET:  nxt_rdata = isel_ff;
      RAMP_OFFSET:  nxt_rdata = ramp_ff;
      BGAP_OFFSET:  nxt_rdata = bgap_ff;
      CHSEL_OFFSET: nxt_rdata = chsel_ff;
      STAT_OFFSET:  nxt_rdata = {4'h0, conv_source};
      default:      nxt_rdata = 8'h00;
    endcase
  end

  // Data only in the cycle after the read strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd_en ? nxt_rdata : 8'h00;
    end
  end

  conv_clock_divider #(
    .DIV_W (3)
  ) u_div (
    .clk                (clk),
    .rst_n              (rst_n),
    .conv_clock_divider (isel_ff[DIV_MSB:0]),
    .conv_clk_tick      (conv_clk_tick)
  );

  internal_isolates_a: assert property (@(posedge clk) disable iff (!rst_n)
    conv_source != SRC_EXT |-> external_analog_channel == '0)
    else $error("External channel closed with internal source");
  floating_channel_a: assert property (@(posedge clk) disable iff (!rst_n)
    chsel_ff[3:0] >= 4'h5 ##1 $stable(chsel_ff) |-> external_analog_channel == '0)
    else $error("Missing channel switch closed");
  isel_bit3_a: assert property (@(posedge clk) disable iff (!rst_n)
    isel_ff[3] == 1'b0)
    else $error("Input-select bit 3 set");
  ramp_unused_a: assert property (@(posedge clk) disable iff (!rst_n)
    ramp_ff[6:5] == 2'h0)
    else $error("Reference control bits 6:5 set");
  vref_pin_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    ref_amp_input_select |-> !amp_reference_in_pin)
    else $error("Reference pin on with bandgap input");
  ext_ref_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    reference_source != REF_PIN |-> !ext_reference_pin)
    else $error("External reference pin left on");
  bgap_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_en && addr == BGAP_OFFSET |=> rdata[7:1] == 7'h00)
    else $error("Bandgap unused bits read nonzero");
  write_lands_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && addr == ISEL_OFFSET |=> ##1 conv_source == decode_source($past(wdata[7:4], 2)))
    else $error("Source write not applied");
  pin_override_a: assert property (@(posedge clk) disable iff (!rst_n)
    analog_pin_select[0] |=> pin_dir_override[0] && pin_pullhigh_off[0])
    else $error("Analog pin not overridden");

  ext_route_c: cover property (@(posedge clk) external_analog_channel[4]);
  vss_sel_c: cover property (@(posedge clk) conv_source == SRC_VSS);
  amp_ref_c: cover property (@(posedge clk) reference_source == REF_AMP && ref_amp_enable);
endmodule

// ### sim/adc_front_partner.sv
// Behavioural analog mux and converter clock monitor
`timescale 1ns/1ps
module adc_front_partner
  import adc_front_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         conv_clk_tick,
  input  wire conv_source_t conv_source,
  input  wire logic [4:0]   external_analog_channel,
  output logic [8:0]        tick_gap,
  output logic              mux_short
);
  import adc_front_pkg::*;
  logic [8:0] cnt_ff;
  // Gap counts clocks between converter clock pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff   <= 9'h001;
      tick_gap <= 9'h000;
    end else if (conv_clk_tick) begin
      tick_gap <= cnt_ff;
      cnt_ff   <= 9'h001;
    end else begin
      cnt_ff <= cnt_ff + 9'h001;
    end
  end
  // Closed channel beside an internal source would tie two drivers together
  assign mux_short = (conv_source != SRC_EXT) && (|external_analog_channel);
endmodule

// ### sim/adc_input_reference_select_ctrl_tb.sv
// Self-checking bench for the converter front-end control block
`timescale 1ns/1ps
module adc_input_reference_select_ctrl_tb;
  import adc_front_pkg::*;
  localparam logic [3:0] OFFS [4] = '{4'h0, 4'h1, 4'h2, 4'h5};
  localparam logic [7:0] MSK [4]  = '{8'hF7, 8'h9F, 8'h01, 8'h00};
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic [3:0]   addr = 4'h0;
  logic [7:0]   wdata = 8'h00;
  logic         wr_en = 1'b0;
  logic         rd_en = 1'b0;
  logic [4:0]   pins = 5'h00;
  logic [7:0]   rdata, r, v;
  logic [4:0]   ch, dig_off, pull_off, dir_ovr;
  conv_source_t src;
  ref_source_t  rsrc;
  logic         amp_en, amp_in, amp_pin, ref_pin, bg_en, tick, shorted;
  logic [1:0]   gain;
  logic [8:0]   gap;
  int           fail_count = 0;
  int           samples_checked = 0;
  int           s, c;

  adc_input_reference_select_ctrl dut (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .analog_pin_select(pins), .rdata(rdata),
    .external_analog_channel(ch), .conv_source(src), .ref_amp_enable(amp_en),
    .ref_amp_input_select(amp_in), .amp_reference_in_pin(amp_pin), .reference_source(rsrc),
    .ext_reference_pin(ref_pin), .ref_amp_gain_select(gain), .bandgap_enable(bg_en),
    .conv_clk_tick(tick), .pin_digital_off(dig_off), .pin_pullhigh_off(pull_off),
    .pin_dir_override(dir_ovr));
  adc_front_partner far_side (.clk(clk), .rst_n(rst_n), .conv_clk_tick(tick),
    .conv_source(src), .external_analog_channel(ch), .tick_gap(gap), .mux_short(shorted));

  always #12.5 clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Trailing delay keeps back-to-back strobes out of one time step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 q = rdata;
  endtask
  task automatic settle();
    @(posedge clk);
    #1;
  endtask
  function automatic logic [3:0] exp_src(input logic [3:0] sv);
    case (sv)
      4'h0, 4'h4, 4'hC, 4'hD, 4'hE, 4'hF: return SRC_EXT;
      4'h1: return SRC_VDD;
      4'h2: return SRC_VDD_2;
      4'h3: return SRC_VDD_4;
      4'h5: return SRC_AMP;
      4'h6: return SRC_AMP_2;
      4'h7: return SRC_AMP_4;
      default: return SRC_VSS;
    endcase
  endfunction
  function automatic logic [4:0] exp_ch(input logic [3:0] sv, input logic [3:0] cv);
    if (exp_src(sv) == SRC_EXT && cv inside {4'h0, 4'h1, 4'h3, 4'h4}) return 5'h01 << cv[2:0];
    return 5'h00;
  endfunction
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #(25 * 20000);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h8B7535F2));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    for (int a = 0; a < 6; a++) begin
      rd(a[3:0], r);
      if (a != 4) chk(r, 8'h00);
      else chk(r, SRC_EXT);
    end
    settle();
    chk(rdata, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(OFFS[i], 8'hFF);
      rd(OFFS[i], r);
      chk(r, MSK[i]);
    end
    wr(4'h1, 8'h00);
    $display("test reset_and_masks done");
    for (int i = 0; i < 32; i++) begin
      s = i % 16;
      c = (i < 16) ? i % 5 : $urandom_range(15, 0);
      pins <= 5'($urandom);
      wr(4'h3, 8'(c));
      wr(4'h0, {s[3:0], 1'b1, 3'($urandom)});
      settle();
      chk(src, exp_src(s[3:0]));
      chk(ch, exp_ch(s[3:0], c[3:0]));
      chk(shorted, 1'b0);
      chk({dig_off, pull_off}, {pins, pins});
      chk(dir_ovr, pins);
      rd(4'h4, r);
      chk(r, {4'h0, exp_src(s[3:0])});
    end
    $display("test source_select done");
    wr(4'h2, 8'h01);
    settle();
    chk(bg_en, 1'b1);
    // Bandgap settles before it is chosen as amplifier input
    repeat (16) @(posedge clk);
    // Shared pins handed to analog use before any reference pin is chosen
    pins <= 5'h1F;
    for (int i = 0; i < 32; i++) begin
      v = {1'($urandom), 2'b11, 5'(i)};
      wr(4'h1, v);
      settle();
      chk(amp_en, v[7]);
      chk({amp_in, amp_pin}, {v[4], ~v[4]});
      chk(rsrc, v[3] ? REF_AMP : {1'b0, v[2]});
      chk(ref_pin, v[3:2] == 2'b01);
      chk(gain, v[1:0]);
    end
    $display("test reference done");
    for (int d = 0; d < 8; d++) begin
      wr(4'h0, 8'(d));
      repeat (3 * (1 << d) + 4) @(posedge clk);
      #1;
      chk(gap, 9'(1 << d));
    end
    $display("test divider done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    rd(4'h1, r);
    chk(r, 8'h00);
    chk(src, SRC_EXT);
    $display("test second_reset done");
    tally_and_finish();
  end
endmodule
